//--- core/rfp_bus_if.sv
// Processor register bus between host and access port
`timescale 1ns/1ps
`default_nettype none
interface rfp_bus_if;
   logic [7:0]  bus_addr;
   logic [15:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic        bus_wide;
   logic [15:0] bus_rdata;

   modport device (
      input  bus_addr,
      input  bus_wdata,
      input  bus_wr,
      input  bus_rd,
      input  bus_wide,
      output bus_rdata
   );

   modport host (
      output bus_addr,
      output bus_wdata,
      output bus_wr,
      output bus_rd,
      output bus_wide,
      input  bus_rdata
   );
endinterface
`default_nettype wire

//--- core/rfp_device.sv
// Access port: RAM write pointer and port, endpoint FIFO read port
//
// Operation
// - 12-bit pointer split into high and low
// - Pointer steps by bytes actually written
// - Host waits a cycle before pointer readback
// - Host reads pointer high then low
// - Write-only 16-bit RAM port, readback undefined
// - Host loads pointer before port writes
// - Port write stores bytes, then steps pointer
// - Stored descriptor bytes never cleared by replies
// - No protection where descriptors overlap FIFOs
// - Read-only 16-bit port pops joined FIFO
// - Byte mode: either register gives next byte
// - Word mode: one lane when one byte left
// - Host checks count before draining, never exceeds
// - 12-bit readable count with joined valid flag
// - Only highest join selection bit is kept
`timescale 1ns/1ps
`default_nettype none
module rfp_device (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Processor bus
   rfp_bus_if.device        bus,
   // Packet RAM write path
   output logic             o_ram_we,
   output logic [11:0]      o_ram_addr,
   output logic [1:0]       o_ram_be,
   output logic [15:0]      o_ram_wdata,
   // Joined endpoint FIFO
   input  wire logic [11:0] i_fifo_count,
   input  wire logic [15:0] i_fifo_data,
   output logic             o_fifo_pop,
   output logic [1:0]       o_fifo_pop_bytes,
   // Join selection for the rest of the controller
   output logic [7:0]       o_join
);

   logic [rfp_pkg::PTR_W-1:0] ptr;
   logic [rfp_pkg::CNT_W-1:0] cnt;
   logic [15:0]               rdata;
   logic                      joined;
   logic                      wide_acc;
   logic                      wr_port;
   logic                      rd_port;
   logic [1:0]                take;
   logic [12:0]               next_cnt;

   assign joined    = o_join[rfp_pkg::JOIN_CPU_RD_BIT];
   // An odd address in wide mode falls back to a byte access
   assign wide_acc  = bus.bus_wide && !bus.bus_addr[0];
   assign wr_port   = bus.bus_wr && (bus.bus_addr == rfp_pkg::OFS_PORT_H ||
                                     bus.bus_addr == rfp_pkg::OFS_PORT_L);
   assign rd_port   = bus.bus_rd && (bus.bus_addr == rfp_pkg::OFS_RD_H ||
                                     bus.bus_addr == rfp_pkg::OFS_RD_L);
   assign bus.bus_rdata = rdata;

   // Lanes and fields are fixed; refuse package values they cannot carry
   if (rfp_pkg::ADDR_W != 8) begin : g_addr_w_check
      $error("Address width must be 8");
   end
   if (rfp_pkg::DATA_W != 16) begin : g_data_w_check
      $error("Data width must be 16");
   end
   if (rfp_pkg::PTR_W != 12) begin : g_ptr_w_check
      $error("Pointer width must be 12");
   end
   if (rfp_pkg::CNT_W != 12) begin : g_cnt_w_check
      $error("Count width must be 12");
   end
   if (rfp_pkg::JOIN_CPU_RD_BIT >= rfp_pkg::JOIN_SEL_W) begin : g_join_bit_check
      $error("Read path join bit outside selection field");
   end
   if (rfp_pkg::CNT_VALID_BIT != 7) begin : g_valid_bit_check
      $error("Count valid flag must be bit 7");
   end

   // Byte view of the readable registers
   function automatic logic [7:0] reg_byte(input logic [7:0] a);
      case (a)
         rfp_pkg::OFS_JOIN:  reg_byte = o_join;
         rfp_pkg::OFS_PTR_H: reg_byte = {4'h0, ptr[11:8]};
         rfp_pkg::OFS_PTR_L: reg_byte = ptr[7:0];
         rfp_pkg::OFS_CNT_H: reg_byte = {joined, 3'h0, cnt[11:8]};
         rfp_pkg::OFS_CNT_L: reg_byte = cnt[7:0];
         default:            reg_byte = 8'h00;
      endcase
   endfunction

   // Lowest set bits lose to the highest one
   function automatic logic [5:0] keep_msb(input logic [5:0] v);
      keep_msb = 6'h00;
      for (int i = 0; i < rfp_pkg::JOIN_SEL_W; i++) begin
         if (v[i]) begin
            keep_msb    = 6'h00;
            keep_msb[i] = 1'b1;
         end
      end
   endfunction

   // Bytes popped by this read; zero when nothing joined or empty
   always_comb begin
      take = 2'h0;
      if (rd_port && joined) begin
         if (wide_acc && cnt >= 12'h002) begin
            take = 2'h2;
         end else if (cnt != 12'h000) begin
            take = 2'h1;
         end
      end
   end

   // Pointer load and auto-advance
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr <= rfp_pkg::PTR_RESET;
      end else if (bus.bus_wr && bus.bus_addr == rfp_pkg::OFS_PTR_H) begin
         if (wide_acc) begin
            ptr <= bus.bus_wdata[11:0];
         end else begin
            ptr[11:8] <= bus.bus_wdata[3:0];
         end
      end else if (bus.bus_wr && bus.bus_addr == rfp_pkg::OFS_PTR_L) begin
         ptr[7:0] <= bus.bus_wdata[7:0];
      end else if (wr_port) begin
         ptr <= ptr + (wide_acc ? 12'h002 : 12'h001);
      end
   end

   // RAM store at the pointer before it moves on.
   // Only port writes reach the RAM here, so descriptor bytes
   // survive any number of replies; endpoint traffic into an
   // overlapping area is not blocked.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ram_we    <= 1'b0;
         o_ram_addr  <= rfp_pkg::PTR_RESET;
         o_ram_be    <= 2'h0;
         o_ram_wdata <= 16'h0000;
      end else begin
         o_ram_we <= wr_port;
         if (wr_port) begin
            o_ram_addr  <= ptr;
            o_ram_be    <= wide_acc ? 2'h3 : 2'h1;
            o_ram_wdata <= wide_acc ? bus.bus_wdata : {8'h00, bus.bus_wdata[7:0]};
         end
      end
   end

   // Join selection register
   // Bits 7:6 are stored as written, with no exclusivity
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_join <= rfp_pkg::JOIN_RESET;
      end else if (bus.bus_wr && bus.bus_addr == rfp_pkg::OFS_JOIN) begin
         o_join <= {bus.bus_wdata[7:6], keep_msb(bus.bus_wdata[5:0])};
      end
   end

   // FIFO pop request, one cycle after the read
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fifo_pop       <= 1'b0;
         o_fifo_pop_bytes <= 2'h0;
      end else begin
         o_fifo_pop       <= take != 2'h0;
         o_fifo_pop_bytes <= take;
      end
   end

   // Count net of pops the FIFO has not yet seen, so a read
   // right after a pop never sees a stale, too-high count
   always_comb begin
      next_cnt = {1'b0, i_fifo_count} - {11'h000, o_fifo_pop_bytes} - {11'h000, take};
   end

   // Clamp covers a pop the FIFO has already counted
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= rfp_pkg::CNT_RESET;
      end else begin
         cnt <= next_cnt[12] ? 12'h000 : next_cnt[11:0];
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata <= 16'h0000;
      end else if (rd_port) begin
         case (take)
            2'h2:    rdata <= i_fifo_data;
            2'h1:    rdata <= {8'h00, i_fifo_data[7:0]};
            default: rdata <= 16'h0000;
         endcase
      end else if (bus.bus_rd && wide_acc) begin
         rdata <= {reg_byte(bus.bus_addr), reg_byte(bus.bus_addr | 8'h01)};
      end else if (bus.bus_rd) begin
         rdata <= {8'h00, reg_byte(bus.bus_addr)};
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

//--- core/rfp_host.sv
// Host end: command registers driving the access port bus
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rfp_host (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Access port bus
   rfp_bus_if.host          bus,
   // Software command port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata
);

   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_PTR_L    = 4'h1,
      S_DATA_HI  = 4'h3,
      S_GAP      = 4'h2,
      S_RP_L     = 4'h6,
      S_RP_END   = 4'h7,
      S_CNT_L    = 4'h5,
      S_CNT_END  = 4'h4,
      S_DECIDE   = 4'hC,
      S_FIFO_END = 4'hD
   } rfp_hstate_e;

   rfp_hstate_e state;
   logic [7:0]  b_addr;
   logic [15:0] b_wdata;
   logic        b_wr;
   logic        b_rd;
   logic        wide;
   logic [11:0] ptr_val;
   logic [15:0] data_q;
   logic        loaded;
   logic        err;
   logic [11:0] ptr_rd;
   logic [11:0] cnt_rd;
   logic        cnt_valid;
   logic [15:0] fifo_data;
   logic [1:0]  fifo_nb;
   logic        busy;
   logic        cmd_wr;
   logic        err_set;
   logic        err_clr;

   assign bus.bus_addr  = b_addr;
   assign bus.bus_wdata = b_wdata;
   assign bus.bus_wr    = b_wr;
   assign bus.bus_rd    = b_rd;
   assign bus.bus_wide  = wide;

   assign busy    = state != S_IDLE;
   assign cmd_wr  = i_wr && (i_addr <= rfp_pkg::HOFS_DRAIN || i_addr == rfp_pkg::HOFS_MODE);
   assign err_clr = i_wr && i_addr == rfp_pkg::HOFS_STAT && i_wdata[rfp_pkg::STAT_ERR];
   // Busy commands, data before a pointer, empty or unjoined drain
   assign err_set = (cmd_wr && busy) ||
                    (i_wr && !busy && i_addr == rfp_pkg::HOFS_DATA && !loaded) ||
                    (state == S_DECIDE && (!cnt_valid || cnt_rd == 12'h000));

   // Bus sequencer; strobes last one cycle
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state     <= S_IDLE;
         b_addr    <= 8'h00;
         b_wdata   <= 16'h0000;
         b_wr      <= 1'b0;
         b_rd      <= 1'b0;
         wide      <= 1'b0;
         ptr_val   <= 12'h000;
         data_q    <= 16'h0000;
         loaded    <= 1'b0;
         err       <= 1'b0;
         ptr_rd    <= 12'h000;
         cnt_rd    <= 12'h000;
         cnt_valid <= 1'b0;
         fifo_data <= 16'h0000;
         fifo_nb   <= 2'h0;
      end else begin
         b_wr <= 1'b0;
         b_rd <= 1'b0;
         err  <= (err && !err_clr) || err_set;
         case (state)
            S_IDLE: begin
               if (i_wr) begin
                  case (i_addr)
                     rfp_pkg::HOFS_PTR: begin
                        ptr_val <= i_wdata[11:0];
                        loaded  <= 1'b1;
                        b_wr    <= 1'b1;
                        b_addr  <= rfp_pkg::OFS_PTR_H;
                        b_wdata <= wide ? {4'h0, i_wdata[11:0]} : {12'h000, i_wdata[11:8]};
                        state   <= wide ? S_IDLE : S_PTR_L;
                     end
                     rfp_pkg::HOFS_DATA: begin
                        if (loaded) begin
                           data_q  <= i_wdata;
                           b_wr    <= 1'b1;
                           b_addr  <= wide ? rfp_pkg::OFS_PORT_H : rfp_pkg::OFS_PORT_L;
                           b_wdata <= wide ? i_wdata : {8'h00, i_wdata[7:0]};
                           state   <= wide ? S_GAP : S_DATA_HI;
                        end
                     end
                     rfp_pkg::HOFS_RDPTR: begin
                        b_rd   <= 1'b1;
                        b_addr <= rfp_pkg::OFS_PTR_H;
                        state  <= S_RP_L;
                     end
                     rfp_pkg::HOFS_DRAIN: begin
                        b_rd   <= 1'b1;
                        b_addr <= rfp_pkg::OFS_CNT_H;
                        state  <= S_CNT_L;
                     end
                     rfp_pkg::HOFS_MODE: begin
                        wide <= i_wdata[0];
                     end
                     default: begin
                     end
                  endcase
               end
            end
            S_PTR_L: begin
               b_wr    <= 1'b1;
               b_addr  <= rfp_pkg::OFS_PTR_L;
               b_wdata <= {8'h00, ptr_val[7:0]};
               state   <= S_IDLE;
            end
            S_DATA_HI: begin
               b_wr    <= 1'b1;
               b_addr  <= rfp_pkg::OFS_PORT_H;
               b_wdata <= {8'h00, data_q[15:8]};
               state   <= S_GAP;
            end
            // One idle cycle keeps pointer and count readbacks fresh
            S_GAP: begin
               state <= S_IDLE;
            end
            // Read data stand only after the edge that takes the strobe
            S_RP_L: begin
               if (!b_rd) begin
                  if (wide) begin
                     ptr_rd <= bus.bus_rdata[11:0];
                     state  <= S_IDLE;
                  end else begin
                     ptr_rd[11:8] <= bus.bus_rdata[3:0];
                     b_rd         <= 1'b1;
                     b_addr       <= rfp_pkg::OFS_PTR_L;
                     state        <= S_RP_END;
                  end
               end
            end
            S_RP_END: begin
               if (!b_rd) begin
                  ptr_rd[7:0] <= bus.bus_rdata[7:0];
                  state       <= S_IDLE;
               end
            end
            S_CNT_L: begin
               if (!b_rd) begin
                  if (wide) begin
                     cnt_rd    <= bus.bus_rdata[11:0];
                     cnt_valid <= bus.bus_rdata[8 + rfp_pkg::CNT_VALID_BIT];
                     state     <= S_DECIDE;
                  end else begin
                     cnt_rd[11:8] <= bus.bus_rdata[3:0];
                     cnt_valid    <= bus.bus_rdata[rfp_pkg::CNT_VALID_BIT];
                     b_rd         <= 1'b1;
                     b_addr       <= rfp_pkg::OFS_CNT_L;
                     state        <= S_CNT_END;
                  end
               end
            end
            S_CNT_END: begin
               if (!b_rd) begin
                  cnt_rd[7:0] <= bus.bus_rdata[7:0];
                  state       <= S_DECIDE;
               end
            end
            S_DECIDE: begin
               if (!cnt_valid || cnt_rd == 12'h000) begin
                  state <= S_IDLE;
               end else begin
                  b_rd    <= 1'b1;
                  b_addr  <= rfp_pkg::OFS_RD_H;
                  fifo_nb <= (wide && cnt_rd >= 12'h002) ? 2'h2 : 2'h1;
                  state   <= S_FIFO_END;
               end
            end
            S_FIFO_END: begin
               if (!b_rd) begin
                  fifo_data <= bus.bus_rdata;
                  state     <= S_GAP;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Software readback
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            rfp_pkg::HOFS_STAT:   o_rdata <= {10'h000, fifo_nb, cnt_valid, loaded, err, busy};
            rfp_pkg::HOFS_PTRVAL: o_rdata <= {4'h0, ptr_rd};
            rfp_pkg::HOFS_RDDATA: o_rdata <= fifo_data;
            rfp_pkg::HOFS_COUNT:  o_rdata <= {cnt_valid, 3'h0, cnt_rd};
            rfp_pkg::HOFS_MODE:   o_rdata <= {15'h0000, wide};
            default:              o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

//--- core/rfp_pkg.sv
// Shared constants of the processor RAM/FIFO access port
package rfp_pkg;
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int PTR_W  = 12;
   localparam int CNT_W  = 12;

   // Device register offsets, one byte register each
   localparam logic [7:0] OFS_JOIN   = 8'h65;
   localparam logic [7:0] OFS_PTR_H  = 8'h6C;
   localparam logic [7:0] OFS_PTR_L  = 8'h6D;
   localparam logic [7:0] OFS_PORT_H = 8'h6E;
   localparam logic [7:0] OFS_PORT_L = 8'h6F;
   localparam logic [7:0] OFS_RD_H   = 8'h70;
   localparam logic [7:0] OFS_RD_L   = 8'h71;
   localparam logic [7:0] OFS_CNT_H  = 8'h74;
   localparam logic [7:0] OFS_CNT_L  = 8'h75;

   // Field positions
   localparam int JOIN_CPU_RD_BIT = 1;
   localparam int JOIN_SEL_W      = 6;
   localparam int CNT_VALID_BIT   = 7;

   // Reset values
   localparam logic [7:0]  JOIN_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET  = 12'h000;
   localparam logic [11:0] CNT_RESET  = 12'h000;

   // Host command registers
   localparam logic [3:0] HOFS_PTR    = 4'h0;
   localparam logic [3:0] HOFS_DATA   = 4'h1;
   localparam logic [3:0] HOFS_RDPTR  = 4'h2;
   localparam logic [3:0] HOFS_DRAIN  = 4'h3;
   localparam logic [3:0] HOFS_STAT   = 4'h4;
   localparam logic [3:0] HOFS_PTRVAL = 4'h5;
   localparam logic [3:0] HOFS_RDDATA = 4'h6;
   localparam logic [3:0] HOFS_COUNT  = 4'h7;
   localparam logic [3:0] HOFS_MODE   = 4'h8;
   localparam int         STAT_ERR    = 1;
endpackage

//--- testbench/cpu_ram_fifo_access_port_bench.sv
// Bench: host and device joined, plus a second device driven directly
`timescale 1ns/1ps
`default_nettype none
module cpu_ram_fifo_access_port_bench;
   logic        sys_clk;
   logic        rst;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        ram_we;
   logic [11:0] ram_addr;
   logic [1:0]  ram_be;
   logic [15:0] ram_wdata;
   logic        pop_a;
   logic [7:0]  join_a;
   logic        pop_b;
   logic [1:0]  pop_bytes_b;
   logic [7:0]  mem [256];
   logic [7:0]  fh;
   logic [7:0]  eh;
   logic [11:0] fcnt;
   logic [11:0] p;
   logic [15:0] d;
   logic [7:0]  v;
   logic [7:0]  e;
   logic        see_a;
   logic        see_b;
   logic [31:0] na;
   logic [31:0] nb;
   logic [31:0] nr;
   logic [31:0] qa [$];
   logic [31:0] qb [$];
   logic [31:0] rq [$];
   int          seed;
   int          mismatches;
   int          comparisons;
   wire logic [15:0] fdata = {mem[fh + 8'h01], mem[fh]};

   rfp_bus_if bus_a ();
   rfp_bus_if bus_b ();
   rfp_host i_rfp_host (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_a), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   rfp_device i_rfp_device (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_a), .o_ram_we(ram_we),
      .o_ram_addr(ram_addr), .o_ram_be(ram_be), .o_ram_wdata(ram_wdata), .i_fifo_count(fcnt),
      .i_fifo_data(fdata), .o_fifo_pop(pop_a), .o_fifo_pop_bytes(), .o_join(join_a));
   rfp_device i_rfp_device_b (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_b), .o_ram_we(), .o_ram_addr(),
      .o_ram_be(), .o_ram_wdata(), .i_fifo_count(fcnt), .i_fifo_data(fdata), .o_fifo_pop(pop_b),
      .o_fifo_pop_bytes(pop_bytes_b), .o_join());
   rfp_assertions i_rfp_assertions (.i_sys_clk(sys_clk), .i_rst(rst), .bus_addr(bus_a.bus_addr),
      .bus_wdata(bus_a.bus_wdata), .bus_wr(bus_a.bus_wr), .bus_rd(bus_a.bus_rd), .bus_wide(bus_a.bus_wide),
      .bus_rdata(bus_a.bus_rdata), .o_ram_we(ram_we), .o_ram_addr(ram_addr), .o_ram_be(ram_be),
      .o_ram_wdata(ram_wdata), .o_fifo_pop(pop_a), .o_join(join_a));

   always #50 sys_clk = ~sys_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Software port access; a read leaves {mask, value} for the monitor
   task automatic sw(input logic w, input logic [3:0] a, input logic [15:0] dd, input logic [31:0] note);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= dd;
      wr    <= w;
      rd    <= !w;
      if (!w)
         qa.push_back(note);
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   // Direct device bus access on the second device
   task automatic bx(input logic w, input logic [7:0] a, input logic [15:0] dd, input logic [31:0] note);
      @(posedge sys_clk);
      bus_b.bus_addr  <= a;
      bus_b.bus_wdata <= dd;
      bus_b.bus_wr    <= w;
      bus_b.bus_rd    <= !w;
      if (!w)
         qb.push_back(note);
      @(posedge sys_clk);
      bus_b.bus_wr <= 1'b0;
      bus_b.bus_rd <= 1'b0;
   endtask

   // Issue a command, then poll busy under a bound
   task automatic cmd(input logic [3:0] a, input logic [15:0] dd);
      sw(1'b1, a, dd, 32'h0);
      for (int i = 0; i < 50; i++) begin
         sw(1'b0, rfp_pkg::HOFS_STAT, 16'h0000, 32'h0);
         #1;
         if (rdata[0] === 1'b0)
            return;
      end
      mismatches++;
      tally_and_finish();
   endtask

   always @(posedge sys_clk) begin
      if (see_a) begin
         na = qa.pop_front();
         check(rdata & na[31:16], na[15:0]);
      end
      if (see_b) begin
         nb = qb.pop_front();
         check(bus_b.bus_rdata & nb[31:16], nb[15:0]);
      end
      if (ram_we) begin
         if (rq.size() == 0)
            check(16'h0001, 16'h0000);
         else begin
            nr = rq.pop_front();
            check({4'h0, ram_addr}, {4'h0, nr[27:16]});
            check({14'h0, ram_be}, {14'h0, nr[29:28]});
            check(ram_wdata & {{8{nr[29]}}, 8'hFF}, nr[15:0]);
         end
      end
      see_a <= rd;
      see_b <= bus_b.bus_rd;
      if (pop_b) begin
         fh   <= fh + {6'h00, pop_bytes_b};
         fcnt <= fcnt - {10'h000, pop_bytes_b};
      end
   end

   initial begin
      seed = 49;
      sys_clk = 1'b0;
      rst = 1'b1;
      {addr, wdata, wr, rd, see_a, see_b, fh, fcnt} = '0;
      {bus_b.bus_addr, bus_b.bus_wdata, bus_b.bus_wr, bus_b.bus_rd, bus_b.bus_wide} = '0;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'($random(seed));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      sw(1'b0, rfp_pkg::HOFS_PTRVAL, 16'h0000, {16'hFFFF, 16'h0000});
      bx(1'b0, rfp_pkg::OFS_JOIN, 16'h0000, {16'h00FF, 16'h0000});
      bx(1'b0, rfp_pkg::OFS_PORT_L, 16'h0000, {16'hFFFF, 16'h0000});
      $display("test reset values done");
      // Data before any pointer load, then drain while not joined
      cmd(rfp_pkg::HOFS_DATA, 16'h1234);
      sw(1'b0, rfp_pkg::HOFS_STAT, 16'h0000, {16'h0002, 16'h0002});
      cmd(rfp_pkg::HOFS_STAT, 16'h0002);
      cmd(rfp_pkg::HOFS_DRAIN, 16'h0000);
      sw(1'b0, rfp_pkg::HOFS_STAT, 16'h0000, {16'h000A, 16'h0002});
      cmd(rfp_pkg::HOFS_STAT, 16'h0002);
      sw(1'b0, rfp_pkg::HOFS_STAT, 16'h0000, {16'h0002, 16'h0000});
      $display("test refusals done");
      // Byte mode at a random start, word mode across the top of the RAM
      for (int m = 0; m < 2; m++) begin
         cmd(rfp_pkg::HOFS_MODE, 16'(m));
         p = (m == 1) ? 12'hFFE : 12'($random(seed));
         cmd(rfp_pkg::HOFS_PTR, {4'h0, p});
         for (int k = 0; k < 3; k++) begin
            d = 16'($random(seed));
            if (m == 1)
               rq.push_back({4'b0011, p, d});
            else begin
               rq.push_back({4'b0001, p, 8'h00, d[7:0]});
               rq.push_back({4'b0001, p + 12'h001, 8'h00, d[15:8]});
            end
            p = p + 12'h002;
            cmd(rfp_pkg::HOFS_DATA, d);
         end
         cmd(rfp_pkg::HOFS_RDPTR, 16'h0000);
         sw(1'b0, rfp_pkg::HOFS_PTRVAL, 16'h0000, {16'hFFFF, 4'h0, p});
      end
      $display("test write port done");
      // Join writes keep only the highest path bit; the last joins the read path
      for (int i = 0; i < 6; i++) begin
         v = (i == 5) ? 8'h02 : 8'($random(seed));
         e = v & 8'hC0;
         for (int b = 0; b < 6; b++)
            if (v[b])
               e = (v & 8'hC0) | (8'h01 << b);
         bx(1'b1, rfp_pkg::OFS_JOIN, {8'h00, v}, 32'h0);
         bx(1'b0, rfp_pkg::OFS_JOIN, 16'h0000, {16'h00FF, 8'h00, e});
      end
      fcnt <= 12'h005;
      eh = fh;
      bx(1'b0, rfp_pkg::OFS_CNT_H, 16'h0000, {16'h00FF, 16'h0080});
      bx(1'b0, rfp_pkg::OFS_CNT_L, 16'h0000, {16'h00FF, 16'h0005});
      bx(1'b0, rfp_pkg::OFS_RD_H, 16'h0000, {16'h00FF, 8'h00, mem[eh]});
      bx(1'b0, rfp_pkg::OFS_RD_L, 16'h0000, {16'h00FF, 8'h00, mem[eh + 8'h01]});
      bx(1'b0, rfp_pkg::OFS_CNT_L, 16'h0000, {16'h00FF, 16'h0003});
      bus_b.bus_wide <= 1'b1;
      bx(1'b0, rfp_pkg::OFS_RD_H, 16'h0000, {16'hFFFF, mem[eh + 8'h03], mem[eh + 8'h02]});
      bx(1'b0, rfp_pkg::OFS_CNT_H, 16'h0000, {16'hFFFF, 16'h8001});
      bx(1'b0, rfp_pkg::OFS_RD_H, 16'h0000, {16'hFFFF, 8'h00, mem[eh + 8'h04]});
      bx(1'b0, rfp_pkg::OFS_RD_H, 16'h0000, {16'hFFFF, 16'h0000});
      bx(1'b0, rfp_pkg::OFS_CNT_H, 16'h0000, {16'hFFFF, 16'h8000});
      $display("test read port done");
      repeat (3) @(posedge sys_clk);
      check(16'(qa.size() + qb.size() + rq.size()), 16'h0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- testbench/rfp_assertions.sv
// Concurrent checks on the bus between host end and access port
`timescale 1ns/1ps
`default_nettype none
module rfp_assertions (
   // Clock and reset
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   // Bus signals
   input wire logic [7:0]  bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic        bus_wide,
   input wire logic [15:0] bus_rdata,
   // Device outputs
   input wire logic        o_ram_we,
   input wire logic [11:0] o_ram_addr,
   input wire logic [1:0]  o_ram_be,
   input wire logic [15:0] o_ram_wdata,
   input wire logic        o_fifo_pop,
   input wire logic [7:0]  o_join
);
   logic        touched;
   logic [11:0] nxt;
   wire logic   at_ph   = bus_addr == rfp_pkg::OFS_PORT_H;
   wire logic   port_wr = bus_wr && (at_ph || bus_addr == rfp_pkg::OFS_PORT_L);
   wire logic   ptr_wr  = bus_wr && (bus_addr == rfp_pkg::OFS_PTR_H || bus_addr == rfp_pkg::OFS_PTR_L);

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // Pointer known from stores only; a direct load hides it until the next store
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         touched <= 1'b0;
         nxt     <= rfp_pkg::PTR_RESET;
      end else if (ptr_wr) begin
         touched <= 1'b1;
      end else if (o_ram_we) begin
         touched <= 1'b0;
         nxt     <= o_ram_addr + ((o_ram_be == 2'b11) ? 12'h002 : 12'h001);
      end
   end

   store_on_write_a: assert property (port_wr |=> o_ram_we)
      else $error("No RAM store after a port write");
   no_stray_store_a: assert property (!port_wr |=> !o_ram_we)
      else $error("RAM store without a port write");
   word_store_a: assert property (
      port_wr && bus_wide && at_ph |=> o_ram_be == 2'b11 && o_ram_wdata == $past(bus_wdata))
      else $error("Word store has wrong lanes or data");
   byte_store_a: assert property (
      port_wr && !(bus_wide && at_ph) |=> o_ram_be == 2'b01 && o_ram_wdata[7:0] == $past(bus_wdata[7:0]))
      else $error("Byte store has wrong lanes or data");
   ptr_step_a: assert property (o_ram_we && !touched |-> o_ram_addr == nxt)
      else $error("Store address did not follow previous store");
   ptr_read_high_a: assert property (
      bus_rd && bus_addr == rfp_pkg::OFS_PTR_H && !touched
      |=> ($past(bus_wide) ? bus_rdata == {4'h0, nxt} : bus_rdata[7:0] == {4'h0, nxt[11:8]}))
      else $error("Pointer high readback wrong");
   ptr_read_low_a: assert property (
      bus_rd && bus_addr == rfp_pkg::OFS_PTR_L && !touched |=> bus_rdata[7:0] == nxt[7:0])
      else $error("Pointer low readback wrong");
   no_pop_unjoined_a: assert property (!o_join[1] |-> !o_fifo_pop)
      else $error("FIFO popped while not joined");
   join_single_a: assert property ($onehot0(o_join[5:0]))
      else $error("More than one join selection active");

   cover property (port_wr && bus_wide && at_ph);
   cover property (port_wr && !bus_wide);
   cover property (bus_rd && bus_addr == rfp_pkg::OFS_PTR_L && !touched);
endmodule
`default_nettype wire
